// ---- hw/umc_params.svh ----
`ifndef UMC_PARAMS_SVH
`define UMC_PARAMS_SVH
`define UMC_ADDR_CMD       8'h00
`define UMC_ADDR_MODE      8'h04
`define UMC_ADDR_STATUS    8'h14
`define UMC_ADDR_DIVISOR   8'h20
`define UMC_ADDR_TIMEOUT   8'h24
`define UMC_ADDR_GUARD     8'h28
`define UMC_ADDR_RATIO     8'h40
`define UMC_ADDR_ERRORS    8'h44
`define UMC_ADDR_IRFILTER  8'h4C
`define UMC_ADDR_LINECODE  8'h50
`define UMC_ADDR_LOCK      8'hE4
`define UMC_RATIO_RESET    11'h174
`define UMC_LINECODE_RESET 32'h30011004
`define UMC_LINECODE_FIXED 32'h20000000
`define UMC_LOCK_KEY       24'h555341
`define UMC_CMD_RESTART    0
`define UMC_MODE_OVER      2
`define UMC_LC_DRIFT       30
`define UMC_LC_RX_POL      28
`define UMC_LC_RX_LEAD_PATTERN       25:24
`define UMC_LC_RX_LEAD_LENGTH       19:16
`define UMC_LC_TX_POL      12
`define UMC_LC_TX_LEAD_PATTERN       9:8
`define UMC_LC_TX_LEAD_LENGTH       3:0
`define UMC_OVS_16         11'h010
`define UMC_OVS_8          11'h008
`define UMC_LEAD_ONES      2'h0
`define UMC_LEAD_ZEROS     2'h1
`define UMC_LEAD_ZERO_ONE  2'h2
`endif

// ---- hw/umc_pkg.sv ----
package umc_pkg;
	typedef enum logic [1:0] {UMC_ASYNC, UMC_SYNC, UMC_SPI, UMC_SMARTCARD} umc_mode_e;
	typedef enum logic {UMC_LEAD_IDLE, UMC_LEAD_SEND} umc_lead_e;
	typedef struct packed {
		logic [15:0] div_cnt;
		logic [10:0] sub_cnt;
		logic        tick;
	} umc_baud_s;
	typedef struct packed {
		logic [16:0] cnt;
		logic        armed;
		logic        flag;
	} umc_timer_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		umc_mode_e   mode;
		logic        over;
		logic [15:0] divisor;
		logic [16:0] to_val;
		logic [7:0]  tg_val;
		logic [10:0] ratio;
		logic [7:0]  err_cnt;
		logic [7:0]  ir_filter;
		logic        drift;
		logic        rx_pol;
		logic [1:0]  rx_lead_pattern;
		logic [3:0]  rx_lead_length;
		logic        tx_pol;
		logic [1:0]  tx_lead_pattern;
		logic [3:0]  tx_lead_length;
		logic        lock;
		logic        restart;
		logic [7:0]  guard_cnt;
		logic        guard_busy;
		umc_lead_e   lead_st;
		logic [3:0]  lead_idx;
		logic        lead_bit;
		logic [1:0]  rx_sync;
		logic [3:0]  rx_match;
		logic        rx_found;
		logic        tx_first;
		logic        tx_second;
		logic        rx_bit;
		logic        drift_en;
	} umc_top_s;
endpackage

// ---- hw/umc_baud_gen.sv ----
`timescale 1ns/1ps
`include "umc_params.svh"
module umc_baud_gen (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire umc_pkg::umc_mode_e mode,
	input  wire logic              over,
	input  wire logic [15:0]       divisor,
	input  wire logic [10:0]       ratio,
	output logic                   bit_tick
);
	umc_pkg::umc_baud_s st_reg;
	umc_pkg::umc_baud_s st_next;
	logic [10:0]        limit;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		case (mode)
			umc_pkg::UMC_ASYNC: limit = over ? `UMC_OVS_8 : `UMC_OVS_16;
			umc_pkg::UMC_SMARTCARD: limit = ratio;
			default: limit = 11'h001;
		endcase
		if (divisor == 16'h0000 || (mode == umc_pkg::UMC_SMARTCARD && ratio == 11'h000))
		begin
			st_next.div_cnt = 16'h0000;
			st_next.sub_cnt = 11'h000;
		end
		else if (st_reg.div_cnt + 16'h0001 >= divisor)
		begin
			st_next.div_cnt = 16'h0000;
			if (st_reg.sub_cnt + 11'h001 >= limit)
			begin
				st_next.sub_cnt = 11'h000;
				st_next.tick = 1'b1;
			end
			else
				st_next.sub_cnt = st_reg.sub_cnt + 11'h001;
		end
		else
			st_next.div_cnt = st_reg.div_cnt + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end

	assign bit_tick = st_reg.tick;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_div_zero;
		clk_en && divisor == 16'h0000 |=> !bit_tick;
	endproperty
	a_div_zero: assert property (p_div_zero) else $error("tick with zero divisor");
	property p_ratio_zero;
		clk_en && mode == umc_pkg::UMC_SMARTCARD && ratio == 11'h000 |=> !bit_tick;
	endproperty
	a_ratio_zero: assert property (p_ratio_zero) else $error("tick with zero ratio");
endmodule // umc_baud_gen

// ---- hw/umc_idle_timer.sv ----
`timescale 1ns/1ps
`include "umc_params.svh"
module umc_idle_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        bit_tick,
	input  wire logic        restart,
	input  wire logic [16:0] to_val,
	output logic             timeout
);
	umc_pkg::umc_timer_s st_reg;
	umc_pkg::umc_timer_s st_next;
	logic                expire;

	////////////////////////////////////////////////////////////////////////////////
	// Expiry is judged before the restart so an expiry in the restart cycle is kept.
	always_comb
	begin
		st_next = st_reg;
		expire = st_reg.armed && bit_tick && (st_reg.cnt + 17'h00001 >= to_val);
		if (to_val == 17'h00000)
		begin
			st_next.armed = 1'b0;
			st_next.flag = 1'b0;
			st_next.cnt = 17'h00000;
		end
		else if (restart)
		begin
			st_next.cnt = 17'h00000;
			st_next.armed = 1'b1;
			st_next.flag = expire;
		end
		else if (expire)
		begin
			st_next.flag = 1'b1;
			st_next.armed = 1'b0;
		end
		else if (st_reg.armed && bit_tick)
			st_next.cnt = st_reg.cnt + 17'h00001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else if (clk_en)
			st_reg <= st_next;
	end

	assign timeout = st_reg.flag;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_to_zero;
		clk_en && to_val == 17'h00000 |=> !timeout;
	endproperty
	a_to_zero: assert property (p_to_zero) else $error("time-out with zero value");
	property p_to_one;
		clk_en && st_reg.armed && bit_tick && to_val == 17'h00001 && !restart |=> timeout;
	endproperty
	a_to_one: assert property (p_to_one) else $error("time-out missed");
endmodule // umc_idle_timer

// ---- hw/umc_top.sv ----
`timescale 1ns/1ps
`include "umc_params.svh"
module umc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sc_error,
	input  wire logic        tx_char_done,
	input  wire logic        tx_frame_start,
	input  wire logic        tx_data_bit,
	input  wire logic        rx_half_first,
	input  wire logic        rx_line_pin,
	output logic             bit_tick,
	output logic             rx_timeout,
	output logic             tx_guard_busy,
	output logic             tx_lead_active,
	output logic             tx_lead_bit,
	output logic             rx_lead_found,
	output logic      [7:0]  ir_filter,
	output logic             drift_recovery_en,
	output logic             tx_code_first,
	output logic             tx_code_second,
	output logic             rx_code_bit
);
	umc_pkg::umc_top_s st_reg;
	umc_pkg::umc_top_s st_next;
	logic              acc;
	logic              wr;
	logic              rd_clear;
	logic              unlocked;
	logic              exp_bit;
	localparam logic [31:0] lc_reset = `UMC_LINECODE_RESET;

	////////////////////////////////////////////////////////////////////////////////
	// Lead pattern bit for a given bit position, inverted under set polarity.
	function automatic logic lead_bit_f(logic [1:0] code, logic [3:0] idx, logic pol);
		logic b;
		case (code)
			`UMC_LEAD_ONES: b = 1'b1;
			`UMC_LEAD_ZEROS: b = 1'b0;
			`UMC_LEAD_ZERO_ONE: b = idx[0];
			default: b = ~idx[0];
		endcase
		return b ^ pol;
	endfunction

	umc_baud_gen u_baud (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.mode    (st_reg.mode),
		.over    (st_reg.over),
		.divisor (st_reg.divisor),
		.ratio   (st_reg.ratio),
		.bit_tick(bit_tick)
	);

	umc_idle_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.bit_tick(bit_tick),
		.restart (st_reg.restart),
		.to_val  (st_reg.to_val),
		.timeout (rx_timeout)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register effects and pready both land on the first access edge,
	// so a read and its clearing side effect see exactly the same counter value.
	always_comb
	begin
		st_next = st_reg;
		acc = psel && penable && !st_reg.pready;
		wr = acc && pwrite;
		rd_clear = acc && !pwrite && paddr == `UMC_ADDR_ERRORS;
		unlocked = !st_reg.lock;
		st_next.pready = acc;
		st_next.pslverr = 1'b0;
		st_next.restart = 1'b0;
		if (acc)
		begin
			st_next.prdata = 32'h00000000;
			case (paddr)
				`UMC_ADDR_CMD: ;
				`UMC_ADDR_MODE:
					st_next.prdata = {29'h0, st_reg.over, st_reg.mode};
				`UMC_ADDR_STATUS:
					st_next.prdata = {29'h0, tx_lead_active, tx_guard_busy, rx_timeout};
				`UMC_ADDR_DIVISOR: st_next.prdata = {16'h0000, st_reg.divisor};
				`UMC_ADDR_TIMEOUT: st_next.prdata = {15'h0000, st_reg.to_val};
				`UMC_ADDR_GUARD: st_next.prdata = {24'h000000, st_reg.tg_val};
				`UMC_ADDR_RATIO: st_next.prdata = {21'h000000, st_reg.ratio};
				`UMC_ADDR_ERRORS: st_next.prdata = {24'h000000, st_reg.err_cnt};
				`UMC_ADDR_IRFILTER: st_next.prdata = {24'h000000, st_reg.ir_filter};
				`UMC_ADDR_LINECODE:
				begin
					st_next.prdata = `UMC_LINECODE_FIXED;
					st_next.prdata[`UMC_LC_DRIFT] = st_reg.drift;
					st_next.prdata[`UMC_LC_RX_POL] = st_reg.rx_pol;
					st_next.prdata[`UMC_LC_RX_LEAD_PATTERN] = st_reg.rx_lead_pattern;
					st_next.prdata[`UMC_LC_RX_LEAD_LENGTH] = st_reg.rx_lead_length;
					st_next.prdata[`UMC_LC_TX_POL] = st_reg.tx_pol;
					st_next.prdata[`UMC_LC_TX_LEAD_PATTERN] = st_reg.tx_lead_pattern;
					st_next.prdata[`UMC_LC_TX_LEAD_LENGTH] = st_reg.tx_lead_length;
				end
				`UMC_ADDR_LOCK: st_next.prdata = {31'h0, st_reg.lock};
				default: st_next.pslverr = 1'b1;
			endcase
		end
		if (wr)
		begin
			case (paddr)
				`UMC_ADDR_CMD:
					st_next.restart = pwdata[`UMC_CMD_RESTART];
				`UMC_ADDR_MODE:
					if (unlocked)
					begin
						st_next.mode = umc_pkg::umc_mode_e'(pwdata[1:0]);
						st_next.over = pwdata[`UMC_MODE_OVER];
					end
				`UMC_ADDR_DIVISOR:
					if (unlocked)
						st_next.divisor = pwdata[15:0];
				`UMC_ADDR_TIMEOUT:
					if (unlocked)
						st_next.to_val = pwdata[16:0];
				`UMC_ADDR_GUARD:
					if (unlocked)
						st_next.tg_val = pwdata[7:0];
				`UMC_ADDR_RATIO:
					if (unlocked)
						st_next.ratio = pwdata[10:0];
				`UMC_ADDR_IRFILTER:
					if (unlocked)
						st_next.ir_filter = pwdata[7:0];
				`UMC_ADDR_LINECODE:
					if (unlocked)
					begin
						st_next.drift = pwdata[`UMC_LC_DRIFT];
						st_next.rx_pol = pwdata[`UMC_LC_RX_POL];
						st_next.rx_lead_pattern = pwdata[`UMC_LC_RX_LEAD_PATTERN];
						st_next.rx_lead_length = pwdata[`UMC_LC_RX_LEAD_LENGTH];
						st_next.tx_pol = pwdata[`UMC_LC_TX_POL];
						st_next.tx_lead_pattern = pwdata[`UMC_LC_TX_LEAD_PATTERN];
						st_next.tx_lead_length = pwdata[`UMC_LC_TX_LEAD_LENGTH];
					end
				`UMC_ADDR_LOCK:
					if (pwdata[31:8] == `UMC_LOCK_KEY)
						st_next.lock = pwdata[0];
				default: ;
			endcase
		end

		// A new error in the clearing cycle survives as a count of one.
		if (sc_error)
		begin
			if (rd_clear)
				st_next.err_cnt = 8'h01;
			else if (st_reg.err_cnt != 8'hFF)
				st_next.err_cnt = st_reg.err_cnt + 8'h01;
		end
		else if (rd_clear)
			st_next.err_cnt = 8'h00;

		// Drift tolerance is only offered while the over bit is clear (16x oversampling in async mode).
		st_next.drift_en = st_reg.drift && !st_reg.over;

		// Guard gap between characters, counted in bit periods.
		// A zero guard value takes priority, so zeroing it ends a running gap at once.
		if (st_reg.tg_val == 8'h00)
			st_next.guard_busy = 1'b0;
		else if (tx_char_done)
		begin
			st_next.guard_busy = 1'b1;
			st_next.guard_cnt = st_reg.tg_val;
		end
		else if (st_reg.guard_busy && bit_tick)
		begin
			st_next.guard_cnt = st_reg.guard_cnt - 8'h01;
			if (st_reg.guard_cnt == 8'h01)
				st_next.guard_busy = 1'b0;
		end

		// Transmit lead sequence ahead of each frame.
		case (st_reg.lead_st)
			umc_pkg::UMC_LEAD_IDLE:
				if (tx_frame_start && st_reg.tx_lead_length != 4'h0)
				begin
					st_next.lead_st = umc_pkg::UMC_LEAD_SEND;
					st_next.lead_idx = 4'h0;
				end
			umc_pkg::UMC_LEAD_SEND:
				if (bit_tick)
				begin
					st_next.lead_idx = st_reg.lead_idx + 4'h1;
					if (st_reg.lead_idx + 4'h1 >= st_reg.tx_lead_length)
						st_next.lead_st = umc_pkg::UMC_LEAD_IDLE;
				end
			default: st_next.lead_st = umc_pkg::UMC_LEAD_IDLE;
		endcase
		st_next.lead_bit = lead_bit_f(st_reg.tx_lead_pattern, st_next.lead_idx, st_reg.tx_pol);

		// Receive lead detection on the synchronised line, sampled once per bit.
		st_next.rx_sync = {st_reg.rx_sync[0], rx_line_pin};
		st_next.rx_found = 1'b0;
		exp_bit = lead_bit_f(st_reg.rx_lead_pattern, st_reg.rx_match, st_reg.rx_pol);
		if (st_reg.rx_lead_length == 4'h0)
			st_next.rx_match = 4'h0;
		else if (bit_tick)
		begin
			if (st_reg.rx_sync[1] != exp_bit)
				st_next.rx_match = 4'h0;
			else if (st_reg.rx_match + 4'h1 >= st_reg.rx_lead_length)
			begin
				st_next.rx_match = 4'h0;
				st_next.rx_found = 1'b1;
			end
			else
				st_next.rx_match = st_reg.rx_match + 4'h1;
		end

		// Mid-bit line code: the first half level is data xor polarity.
		st_next.tx_first = tx_data_bit ^ st_reg.tx_pol;
		st_next.tx_second = ~(tx_data_bit ^ st_reg.tx_pol);
		st_next.rx_bit = rx_half_first ^ st_reg.rx_pol;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.ratio <= `UMC_RATIO_RESET;
			st_reg.drift <= lc_reset[`UMC_LC_DRIFT];
			st_reg.rx_pol <= lc_reset[`UMC_LC_RX_POL];
			st_reg.rx_lead_pattern <= lc_reset[`UMC_LC_RX_LEAD_PATTERN];
			st_reg.rx_lead_length <= lc_reset[`UMC_LC_RX_LEAD_LENGTH];
			st_reg.tx_pol <= lc_reset[`UMC_LC_TX_POL];
			st_reg.tx_lead_pattern <= lc_reset[`UMC_LC_TX_LEAD_PATTERN];
			st_reg.tx_lead_length <= lc_reset[`UMC_LC_TX_LEAD_LENGTH];
		end
		else if (clk_en)
			st_reg <= st_next;
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign tx_guard_busy = st_reg.guard_busy;
	assign tx_lead_active = st_reg.lead_st == umc_pkg::UMC_LEAD_SEND;
	assign tx_lead_bit = st_reg.lead_bit;
	assign rx_lead_found = st_reg.rx_found;
	assign ir_filter = st_reg.ir_filter;
	assign drift_recovery_en = st_reg.drift_en;
	assign tx_code_first = st_reg.tx_first;
	assign tx_code_second = st_reg.tx_second;
	assign rx_code_bit = st_reg.rx_bit;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_lock_guard;
		clk_en && wr && st_reg.lock && paddr == `UMC_ADDR_GUARD |=> $stable(st_reg.tg_val);
	endproperty
	a_lock_guard: assert property (p_lock_guard) else $error("locked write took effect");

	property p_err_clear;
		clk_en && rd_clear && !sc_error |=> st_reg.err_cnt == 8'h00;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error count not cleared");

	property p_guard_none;
		clk_en && st_reg.tg_val == 8'h00 && !wr |=> !tx_guard_busy;
	endproperty
	a_guard_none: assert property (p_guard_none) else $error("gap with zero guard");

	property p_guard_start;
		clk_en && tx_char_done && st_reg.tg_val != 8'h00 |=> tx_guard_busy;
	endproperty
	a_guard_start: assert property (p_guard_start) else $error("guard not started");

	property p_lead_off;
		clk_en && !tx_lead_active && st_reg.tx_lead_length == 4'h0 |=> !tx_lead_active;
	endproperty
	a_lead_off: assert property (p_lead_off) else $error("lead sent with zero length");

	property p_rx_off;
		clk_en && st_reg.rx_lead_length == 4'h0 |=> !rx_lead_found;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("lead found with zero length");

	property p_code;
		clk_en |=> tx_code_first == ($past(tx_data_bit) ^ $past(st_reg.tx_pol))
			&& tx_code_second != tx_code_first;
	endproperty
	a_code: assert property (p_code) else $error("line code mismatch");

	property p_key;
		clk_en && wr && paddr == `UMC_ADDR_LOCK && pwdata[31:8] != `UMC_LOCK_KEY
			|=> $stable(st_reg.lock);
	endproperty
	a_key: assert property (p_key) else $error("lock changed with bad key");

	c_lock: cover property (clk_en && wr && paddr == `UMC_ADDR_LOCK && st_next.lock);
	c_guard: cover property (tx_guard_busy ##1 !tx_guard_busy);
	c_found: cover property (rx_lead_found);
endmodule // umc_top

// ---- tb/umc_far_node.sv ----
`timescale 1ns/1ps
module umc_far_node (
	input  wire logic pclk,
	output logic      sc_error,
	output logic      tx_char_done,
	output logic      tx_frame_start,
	output logic      rx_line_pin
);
	// An idle serial line rests high, so the receive pin starts high here.
	initial
	begin
		rx_line_pin = 1'b1;
		sc_error = 1'b0;
		tx_char_done = 1'b0;
		tx_frame_start = 1'b0;
	end
	// Kind 0 is a card error, 1 a character end, 2 a frame start; each is one cycle wide.
	task automatic strobe(input int kind, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			case (kind)
				0: sc_error <= 1'b1;
				1: tx_char_done <= 1'b1;
				default: tx_frame_start <= 1'b1;
			endcase
			@(posedge pclk);
			{sc_error, tx_char_done, tx_frame_start} <= 3'b000;
		end
	endtask
	// The remote node holds a steady line level; called just after a clock edge.
	task automatic hold_line(input logic v);
		rx_line_pin <= v;
	endtask
endmodule // umc_far_node

// ---- tb/tb_usart_timing_manchester_config.sv ----
`timescale 1ns/1ps
`include "umc_params.svh"
module tb_usart_timing_manchester_config;
	logic        pclk, presetn, psel, penable, pwrite, tx_data_bit, rx_half_first, rerr;
	logic        clk_en, lb;
	logic [7:0]  paddr, ir_filter;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, sc_error, tx_char_done, tx_frame_start, rx_line_pin;
	logic        bit_tick, rx_timeout, tx_guard_busy, tx_lead_active, tx_lead_bit;
	logic        rx_lead_found, drift_recovery_en, tx_code_first, tx_code_second, rx_code_bit;
	logic [31:0] mdl [logic [7:0]];
	logic        lock_m;
	int          n_mismatch, n_checks, c, g, p;
	integer      seed;
	wire  [3:0]  mon = {tx_lead_active, tx_guard_busy, rx_timeout, bit_tick};
	always #12.5 pclk = ~pclk;
	umc_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sc_error(sc_error), .tx_char_done(tx_char_done),
		.tx_frame_start(tx_frame_start), .tx_data_bit(tx_data_bit),
		.rx_half_first(rx_half_first), .rx_line_pin(rx_line_pin), .bit_tick(bit_tick),
		.rx_timeout(rx_timeout), .tx_guard_busy(tx_guard_busy), .tx_lead_active(tx_lead_active),
		.tx_lead_bit(tx_lead_bit), .rx_lead_found(rx_lead_found), .ir_filter(ir_filter),
		.drift_recovery_en(drift_recovery_en), .tx_code_first(tx_code_first),
		.tx_code_second(tx_code_second), .rx_code_bit(rx_code_bit));
	umc_far_node i_node (.pclk(pclk), .sc_error(sc_error), .tx_char_done(tx_char_done),
		.tx_frame_start(tx_frame_start), .rx_line_pin(rx_line_pin));
	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		n_checks++;
		if (v !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, v);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (k >= 16)
		begin
			n_mismatch++;
			final_report();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	function automatic logic [31:0] wmask(input logic [7:0] a);
		case (a)
			`UMC_ADDR_MODE: return 32'h7;
			`UMC_ADDR_DIVISOR: return 32'hFFFF;
			`UMC_ADDR_TIMEOUT: return 32'h1FFFF;
			`UMC_ADDR_RATIO: return 32'h7FF;
			`UMC_ADDR_LINECODE: return 32'h530F130F;
			`UMC_ADDR_GUARD, `UMC_ADDR_IRFILTER: return 32'hFF;
			default: return 32'h0;
		endcase
	endfunction
	// The model keeps what each configuration register should read back, lock included.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == `UMC_ADDR_LOCK && d[31:8] == 24'h555341)
			lock_m = d[0];
		mdl[`UMC_ADDR_LOCK] = {31'h0, lock_m};
		if (wmask(a) != 32'h0 && !lock_m)
			mdl[a] = (d & wmask(a)) | (a == `UMC_ADDR_LINECODE ? 32'h20000000 : 32'h0);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), mdl[a], rdat);
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (mdl[a]) mdl[a] = 32'h0;
		mdl[`UMC_ADDR_RATIO] = 32'h174;
		mdl[`UMC_ADDR_LINECODE] = 32'h30011004;
		lock_m = 1'b0;
		foreach (mdl[a]) rd(a);
	endtask
	// Counts bit ticks while monitor k is high; a hang here ends the run.
	task automatic span(input int k);
		g = 0;
		c = 0;
		while (mon[k] !== 1'b1 && g < 8)
		begin
			@(posedge pclk);
			g++;
		end
		lb = tx_lead_bit;
		while (mon[k] === 1'b1 && g < 3000)
		begin
			if (bit_tick === 1'b1)
				c++;
			@(posedge pclk);
			g++;
		end
		if (g >= 3000)
		begin
			n_mismatch++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	int bm[7] = '{0, 4, 1, 2, 3, 3, 1};
	int bd[7] = '{2, 3, 5, 3, 2, 2, 0};
	int br[7] = '{1, 1, 1, 1, 3, 0, 1};
	int rl[5] = '{1, 1, 0, 0, 1};
	int rp[5] = '{32'h00030000, 32'h10030000, 32'h01050000, 32'h100F0000, 32'h0};
	logic [7:0] wmask_keys[7] = '{`UMC_ADDR_MODE, `UMC_ADDR_DIVISOR, `UMC_ADDR_TIMEOUT,
		`UMC_ADDR_GUARD, `UMC_ADDR_RATIO, `UMC_ADDR_IRFILTER, `UMC_ADDR_LINECODE};
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, tx_data_bit, rx_half_first} = 7'h0;
		paddr = 8'h00;
		clk_en = 1'b1;
		pwdata = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		seed = 32'hB82A;
		foreach (wmask_keys[i]) mdl[wmask_keys[i]] = 32'h0;
		do_reset();
		for (int i = 0; i < 7; i++)
		begin
			wr(`UMC_ADDR_RATIO, br[i]);
			wr(`UMC_ADDR_DIVISOR, bd[i]);
			wr(`UMC_ADDR_MODE, bm[i]);
			p = bm[i] == 0 ? bd[i] * 16 : bm[i] == 4 ? bd[i] * 8 : bm[i] == 3 ? bd[i] * br[i] : bd[i];
			repeat (100) @(posedge pclk);
			c = 0;
			repeat (p ? 10 * p : 200) @(posedge pclk) c += (bit_tick === 1'b1);
			chk("bit ticks", p ? 10 : 0, c);
		end
		wr(`UMC_ADDR_MODE, 1);
		wr(`UMC_ADDR_DIVISOR, 8);
		wr(`UMC_ADDR_TIMEOUT, 3);
		wr(`UMC_ADDR_CMD, 1);
		for (c = 0; rx_timeout !== 1'b1 && c < 100; c++) @(posedge pclk);
		chk("timeout delay", 1, c >= 14 && c <= 26);
		wr(`UMC_ADDR_CMD, 1);
		@(posedge pclk);
		chk("timeout restart", 0, rx_timeout);
		wr(`UMC_ADDR_TIMEOUT, 0);
		wr(`UMC_ADDR_CMD, 1);
		c = 0;
		repeat (100) @(posedge pclk) c += (rx_timeout === 1'b1);
		chk("timeout disabled", 0, c);
		for (int t = 0; t < 3; t++)
		begin
			wr(`UMC_ADDR_GUARD, t);
			i_node.strobe(1, 1);
			span(2);
			chk("guard ticks", t, c);
			wr(`UMC_ADDR_LINECODE, 32'h30011000 | ((t + 1) << 8) | (t * 7 + t / 2));
			i_node.strobe(2, 1);
			span(3);
			chk("lead ticks", t * 7 + t / 2, c);
			if (t > 0)
				chk("lead first bit", (t + 1 == 3) ^ 1, lb);
		end
		// A steady line matches an all-ones or all-zeros lead of the expected level.
		for (int q = 0; q < 5; q++)
		begin
			wr(`UMC_ADDR_LINECODE, rp[q]);
			i_node.hold_line(rl[q][0]);
			repeat (200) @(posedge pclk);
			c = 0;
			repeat (240) @(posedge pclk) c += (rx_lead_found === 1'b1);
			p = rp[q][19:16] == 0 ? 0
				: rl[q] == ((rp[q][25:24] == 0) ^ rp[q][28]) ? 30 / rp[q][19:16] : 0;
			chk("lead found", p, c);
		end
		i_node.hold_line(1'b1);
		i_node.strobe(0, 5);
		apb(1'b0, `UMC_ADDR_ERRORS, 32'h0);
		chk("error count", 5, rdat);
		apb(1'b0, `UMC_ADDR_ERRORS, 32'h0);
		chk("error count cleared", 0, rdat);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped error", 1, rerr);
		// With the clock enable low the four monitored outputs must hold, as the baud generator is frozen too.
		clk_en <= 1'b0;
		@(posedge pclk);
		g = mon;
		c = 0;
		repeat (50) @(posedge pclk) c += (mon !== g[3:0]);
		clk_en <= 1'b1;
		chk("frozen outputs", 0, c);
		for (int q = 0; q < 2; q++)
		begin
			wr(`UMC_ADDR_LINECODE, q ? 32'h50001000 : 32'h40000000);
			wr(`UMC_ADDR_MODE, q * 4);
			repeat (8)
			begin
				tx_data_bit <= $random(seed);
				rx_half_first <= $random(seed);
				repeat (2) @(posedge pclk);
				chk("tx first half", tx_data_bit ^ q[0], tx_code_first);
				chk("tx second half", !(tx_data_bit ^ q[0]), tx_code_second);
				chk("rx bit", rx_half_first ^ q[0], rx_code_bit);
			end
			chk("drift enable", !q[0], drift_recovery_en);
		end
		// Lock toggles with good and bad keys while random writes go on.
		for (int i = 0; i < 32; i++)
		begin
			if (i % 4 == 3)
				wr(`UMC_ADDR_LOCK, {(i % 8 == 3) ? 24'h0FACE0 : 24'h555341, 7'h0, i[3]});
			wr(wmask_keys[$unsigned($random(seed)) % 7], $random(seed));
		end
		foreach (mdl[a]) rd(a);
		chk("filter output", mdl[`UMC_ADDR_IRFILTER], ir_filter);
		do_reset();
		final_report();
	end
endmodule // tb_usart_timing_manchester_config
